// [verilog/alu_slice_pkg.sv]
`default_nettype none

package alu_slice_pkg;

	// Data path and register bus widths.
	localparam int unsigned WORD_W = 32;
	localparam int unsigned SHIFT_AMT_W = 8;
	localparam int unsigned IMM_AMT_W = 6;
	localparam int unsigned IDX_W = 6;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned FLAGS_W = 4;
	localparam int unsigned TRANS_ACTIVE_BIT = 1;

	// Word indices of the registers; the byte address is four times the index.
	localparam logic [5:0] IDX_FIRST = 6'h00;
	localparam logic [5:0] IDX_SECOND = 6'h01;
	localparam logic [5:0] IDX_CTRL = 6'h02;
	localparam logic [5:0] IDX_RESULT = 6'h03;
	localparam logic [5:0] IDX_FLAGS = 6'h04;

	// Reset values and fixed bus answers.
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic HRESP_OKAY = 1'b0;

	// Shift and count figures used by the shifter and the leading zero count.
	localparam logic [7:0] AMT_ZERO = 8'h00;
	localparam logic [7:0] WORD_BITS = 8'h20;
	localparam logic [5:0] CLZ_ALL_ZERO = 6'h20;

	// Operation select; the control word carries its ordinal.
	typedef enum logic [4:0] {
		OP_AND,
		OP_EXCLUSIVE_OR,
		OP_BITWISE_OR,
		OP_AND_NOT,
		OP_OR_NOT,
		OP_LOGICAL_SHIFT_LEFT,
		OP_LOGICAL_SHIFT_RIGHT,
		OP_ARITH_SHIFT_RIGHT,
		OP_ROTATE_RIGHT,
		OP_ROTATE_RIGHT_EXTEND,
		OP_LEADING_ZERO_COUNT,
		OP_ADD,
		OP_ADD_WITH_CARRY,
		OP_SUB,
		OP_SUBTRACT_WITH_BORROW,
		OP_COMPARE_SUB,
		OP_COMPARE_ADD_NEGATIVE
	} op_t;

	// Control word; a write to it starts one operation.
	typedef struct packed {
		logic [15:0] spare;
		logic op2_carry;
		logic op2_carry_valid;
		logic only_if_higher;
		logic [5:0] imm_amount;
		logic amount_from_reg;
		logic set_flags;
		logic [4:0] opcode;
	} ctrl_t;

	// Condition flags, negative down to overflow.
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} flags_t;

	// What one operation produces.
	typedef struct packed {
		logic [31:0] result;
		logic write_result;
		flags_t flags;
	} exec_t;

	// Kind of bus data phase in progress.
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WRITE,
		PH_READ
	} phase_t;

	// Whole state of the slice.
	typedef struct packed {
		logic [31:0] op_a;
		logic [31:0] op_b;
		ctrl_t ctrl;
		logic [31:0] result;
		flags_t flags;
		phase_t phase;
		logic [5:0] widx;
		logic [31:0] hrdata;
		logic hreadyout;
	} state_t;

endpackage

`default_nettype wire

// [verilog/logic_shift_clz_alu.sv]
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`default_nettype none

module logic_shift_clz_alu #(
	parameter int unsigned DATA_W = 32
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] RESULT_WORD,
	output alu_slice_pkg::flags_t FLAGS_NZCV
);
	import alu_slice_pkg::*;

	// The datapath is built for one word width only.
	if (DATA_W != WORD_W) begin : g_width_check
		$error("logic_shift_clz_alu serves a 32-bit data width only.");
	end

	// Whole state in one register; the operation itself is combinational.
	state_t cur_q;
	state_t nxt_d;
	exec_t ex;
	logic addr_taken;

	// Counts the zero bits above the highest set bit of a word.
	// The found flag keeps the first set bit met from the top; lower ones are ignored.
	function automatic logic [5:0] count_leading(input logic [31:0] w);
		logic [5:0] cnt;
		logic found;
		cnt = CLZ_ALL_ZERO;
		found = 1'b0;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			if (w[i] && !found) begin
				found = 1'b1;
				cnt = 6'(WORD_W - 1 - i);
			end
		end
		return cnt;
	endfunction

	// Adds two words and a carry in, giving the sum with its C and V flags.
	// Subtraction passes the inverted operand with a carry in of one, so C means no borrow.
	// V is set when both addends share a sign that the sum does not.
	function automatic logic [33:0] add_with_flags(
		input logic [31:0] a,
		input logic [31:0] b,
		input logic cin
	);
		logic [32:0] sum;
		logic ovf;
		sum = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
		ovf = (a[31] == b[31]) && (sum[31] != a[31]);
		return {ovf, sum};
	endfunction

	// Runs one operation on the operands and the current flags.
	function automatic exec_t execute(
		input ctrl_t c,
		input logic [31:0] a,
		input logic [31:0] b,
		input flags_t f
	);
		exec_t r;
		logic [7:0] amt;
		logic [63:0] wide;
		logic [63:0] rot;
		logic [33:0] arith;
		logic [31:0] res;
		logic shift_c;
		logic use_shift_c;
		logic arith_flags;
		logic logic_flags;
		logic do_write;
		logic known;
		// Every local starts from a safe value so that no path keeps a stale carry.
		r = '0;
		r.flags = f;
		wide = '0;
		rot = '0;
		arith = '0;
		res = '0;
		shift_c = f.c;
		use_shift_c = 1'b0;
		arith_flags = 1'b0;
		logic_flags = 1'b0;
		do_write = 1'b1;
		known = 1'b1;
		amt = c.amount_from_reg ? b[SHIFT_AMT_W-1:0] : {2'b00, c.imm_amount};
		case (op_t'(c.opcode))
			OP_AND: res = a & b;
			OP_EXCLUSIVE_OR: res = a ^ b;
			OP_BITWISE_OR: res = a | b;
			OP_AND_NOT: res = a & ~b;
			OP_OR_NOT: res = a | ~b;
			// The shifters work on a double-width word, so lengths from 1 to 255 need no
			// special case; the bit next to the kept half is the last one shifted out.
			// left by amount
			OP_LOGICAL_SHIFT_LEFT: begin
				wide = {32'h0000_0000, a} << amt;
				res = wide[31:0];
				shift_c = wide[32];
				use_shift_c = 1'b1;
			end
			OP_LOGICAL_SHIFT_RIGHT: begin
				wide = {a, 32'h0000_0000} >> amt;
				res = wide[63:32];
				shift_c = wide[31];
				use_shift_c = 1'b1;
			end
			OP_ARITH_SHIFT_RIGHT: begin
				wide = 64'($signed({a, 32'h0000_0000}) >>> amt);
				res = wide[63:32];
				shift_c = wide[31];
				use_shift_c = 1'b1;
			end
			// Only five bits of the length matter; a nonzero multiple of 32 keeps the word.
			// bits reinserted on top
			OP_ROTATE_RIGHT: begin
				rot = {a, a} >> amt[4:0];
				res = rot[31:0];
				shift_c = rot[31];
				use_shift_c = 1'b1;
			end
			OP_ROTATE_RIGHT_EXTEND: begin
				res = {f.c, a[31:1]};
				shift_c = a[0];
				use_shift_c = 1'b1;
			end
			OP_LEADING_ZERO_COUNT: begin
				res = {26'h0000000, count_leading(a)};
			end
			OP_ADD: begin
				arith = add_with_flags(a, b, 1'b0);
				arith_flags = 1'b1;
			end
			OP_ADD_WITH_CARRY: begin
				arith = add_with_flags(a, b, f.c);
				arith_flags = 1'b1;
			end
			OP_SUB: begin
				arith = add_with_flags(a, ~b, 1'b1);
				arith_flags = 1'b1;
			end
			OP_SUBTRACT_WITH_BORROW: begin
				arith = add_with_flags(a, ~b, f.c);
				arith_flags = 1'b1;
			end
			OP_COMPARE_SUB: begin
				arith = add_with_flags(a, ~b, 1'b1);
				arith_flags = 1'b1;
				do_write = 1'b0;
			end
			OP_COMPARE_ADD_NEGATIVE: begin
				arith = add_with_flags(a, b, 1'b0);
				arith_flags = 1'b1;
				do_write = 1'b0;
			end
			// Unknown opcodes write nothing, so a stray code leaves result and flags alone.
			default: begin
				known = 1'b0;
				do_write = 1'b0;
			end
		endcase
		// Arithmetic results come from the adder, whose upper bits hold C and V.
		if (arith_flags) begin
			res = arith[31:0];
		end
		// Logical ops and shifts share the N and Z update; the count is left out.
		logic_flags = known && !arith_flags
			&& (op_t'(c.opcode) != OP_LEADING_ZERO_COUNT);
		if (use_shift_c && (op_t'(c.opcode) != OP_ROTATE_RIGHT_EXTEND) && (amt == AMT_ZERO)) begin
			shift_c = f.c;
		end
		r.result = res;
		r.write_result = do_write;
		if (c.set_flags || !do_write) begin
			if (arith_flags) begin
				r.flags = '{n: res[31], z: (res == WORD_RST), c: arith[32], v: arith[33]};
			end else if (logic_flags) begin
				r.flags.n = res[31];
				r.flags.z = (res == WORD_RST);
				if (use_shift_c) begin
					r.flags.c = shift_c;
				end else if (c.op2_carry_valid) begin
					r.flags.c = c.op2_carry;
				end
			end
		end
		if (op_t'(c.opcode) == OP_LEADING_ZERO_COUNT) begin
			r.flags = f;
		end
		// The gate comes last so that it also holds back the flags of any opcode.
		// higher condition gate
		if (c.only_if_higher && !(f.c && !f.z)) begin
			r.result = WORD_RST;
			r.write_result = 1'b0;
			r.flags = f;
		end
		return r;
	endfunction

	// An address phase is taken when the slave is selected for an active transfer on a ready bus.
	assign addr_taken = HSEL && HTRANS[TRANS_ACTIVE_BIT] && HREADY;

	// Operation on the control word arriving in a write data phase.
	assign ex = execute(ctrl_t'(HWDATA), cur_q.op_a, cur_q.op_b, cur_q.flags);

	// Next state: finish the open data phase, then take a new address phase.
	// Execution reads the operand registers as they stood before this data phase,
	// so operands must be written in earlier transfers than the control word.
	always_comb begin
		nxt_d = cur_q;
		case (cur_q.phase)
			PH_WRITE: begin
				case (cur_q.widx)
					IDX_FIRST: nxt_d.op_a = HWDATA;
					IDX_SECOND: nxt_d.op_b = HWDATA;
					IDX_CTRL: begin
						nxt_d.ctrl = ctrl_t'(HWDATA);
						if (ex.write_result) begin
							nxt_d.result = ex.result;
						end
						nxt_d.flags = ex.flags;
					end
					IDX_FLAGS: nxt_d.flags = flags_t'(HWDATA[FLAGS_W-1:0]);
					// Writes to the result word or to unmapped words are ignored.
					default: nxt_d.result = cur_q.result;
				endcase
			end
			PH_READ: begin
				// Read data comes from the registers as they stand once the phase has begun.
				case (cur_q.widx)
					IDX_FIRST: nxt_d.hrdata = cur_q.op_a;
					IDX_SECOND: nxt_d.hrdata = cur_q.op_b;
					IDX_CTRL: nxt_d.hrdata = cur_q.ctrl;
					IDX_RESULT: nxt_d.hrdata = cur_q.result;
					IDX_FLAGS: nxt_d.hrdata = {28'h0000000, cur_q.flags};
					default: nxt_d.hrdata = WORD_RST;
				endcase
				nxt_d.hreadyout = 1'b1;
			end
			PH_IDLE: nxt_d.hreadyout = 1'b1;
			default: nxt_d.hreadyout = 1'b1;
		endcase
		// Reads get one wait state so they see any write just before them.
		// The wait costs a cycle per read but keeps the read mux off the write path.
		if (addr_taken) begin
			nxt_d.widx = HADDR[IDX_LSB+IDX_W-1:IDX_LSB];
			nxt_d.phase = HWRITE ? PH_WRITE : PH_READ;
			nxt_d.hreadyout = HWRITE;
		end else begin
			nxt_d.phase = PH_IDLE;
		end
	end

	// State register with synchronous reset.
	// Reset leaves the bus idle with ready high, so a transfer may follow at once.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			cur_q <= '{
				op_a: WORD_RST,
				op_b: WORD_RST,
				ctrl: ctrl_t'(WORD_RST),
				result: WORD_RST,
				flags: flags_t'(FLAGS_RST),
				phase: PH_IDLE,
				widx: IDX_FIRST,
				hrdata: WORD_RST,
				hreadyout: 1'b1
			};
		end else begin
			cur_q <= nxt_d;
		end
	end

	// Outputs other than HRESP come straight from the state register.
	// HRESP is tied to OKAY because no access is ever refused.
	assign HRDATA = cur_q.hrdata;
	assign HREADYOUT = cur_q.hreadyout;
	assign HRESP = HRESP_OKAY;
	assign RESULT_WORD = cur_q.result;
	assign FLAGS_NZCV = cur_q.flags;

endmodule

`default_nettype wire

// [dv/alu_checks_asserts.sv]
`default_nettype none

module alu_checks (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] RESULT_WORD,
	input wire alu_slice_pkg::flags_t FLAGS_NZCV
);
	timeunit 1ns;
	timeprecision 1ns;
	import alu_slice_pkg::*;
	logic w_q;
	logic [5:0] ix_q;
	logic [31:0] a_q;
	logic [31:0] b_q;
	logic ex;
	logic go;
	logic [4:0] op;

	// Tracks write data phases so the operands behind each execution are known.
	always_ff @(posedge CLOCK) begin
		w_q <= !SYS_RST && HSEL && HTRANS[1] && HREADY && HWRITE;
		ix_q <= HADDR[7:2];
		if (w_q && ix_q == IDX_FIRST)
			a_q <= HWDATA;
		if (w_q && ix_q == IDX_SECOND)
			b_q <= HWDATA;
	end

	// A control write executes; the higher gate is left out of go.
	assign ex = w_q && ix_q == IDX_CTRL;
	assign op = HWDATA[4:0];
	assign go = ex && !HWDATA[13];

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	property p_and; go && op == 5'h00 |=> RESULT_WORD == (a_q & b_q); endproperty
	a_and: assert property (p_and) else $error("and result");
	property p_andn; go && op == 5'h03 |=> RESULT_WORD == (a_q & ~b_q); endproperty
	a_andn: assert property (p_andn) else $error("and-not result");
	property p_keep; ex && !HWDATA[5] && op < 5'h0f |=> $stable(FLAGS_NZCV); endproperty
	a_keep: assert property (p_keep) else $error("flags moved");
	property p_clzf; ex && op == 5'h0a |=> $stable(FLAGS_NZCV); endproperty
	a_clzf: assert property (p_clzf) else $error("count moved flags");
	property p_clz; go && op == 5'h0a && (a_q == 32'h0 || a_q[31])
		|=> RESULT_WORD == (a_q[31] ? 32'h0 : 32'h20); endproperty
	a_clz: assert property (p_clz) else $error("count result");
	property p_adc; go && op == 5'h0c
		|=> RESULT_WORD == a_q + b_q + {31'h0, $past(FLAGS_NZCV.c)}; endproperty
	a_adc: assert property (p_adc) else $error("carry add result");
	property p_rrx; go && op == 5'h09
		|=> RESULT_WORD == {$past(FLAGS_NZCV.c), a_q[31:1]}; endproperty
	a_rrx: assert property (p_rrx) else $error("extend rotate result");
	property p_cmp; go && op == 5'h0f |=> $stable(RESULT_WORD)
		&& FLAGS_NZCV.z == (a_q == b_q) && FLAGS_NZCV.c == (a_q >= b_q); endproperty
	a_cmp: assert property (p_cmp) else $error("compare");
endmodule

bind logic_shift_clz_alu alu_checks chk_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
	.RESULT_WORD(RESULT_WORD), .FLAGS_NZCV(FLAGS_NZCV));

`default_nettype wire

// [dv/decoder_model.sv]
`default_nettype none

module decoder_model (
	input wire logic clock,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Bus idle at time zero.
	initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

	// One single word transfer; write data is inverted once released.
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		hsize <= 3'h2;
		@(posedge clock iff hready);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		@(posedge clock iff hready);
		r = hrdata;
		hsel <= 1'b0;
		hwdata <= ~hwdata;
	endtask
endmodule

`default_nettype wire

// [dv/logic_shift_clz_alu_tb.sv]
`default_nettype none

module logic_shift_clz_alu_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import alu_slice_pkg::*;
	logic clock;
	logic sys_rst;
	logic hsel;
	logic hwrite;
	logic hreadyout;
	logic hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] result_word;
	flags_t flags_nzcv;
	logic [31:0] r;
	logic [31:0] va = 32'hf0f0_1234;
	logic [31:0] vb = 32'h0ff0_00ff;
	int failures = 0;
	int checked = 0;

	logic_shift_clz_alu dut (.CLOCK(clock), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RESULT_WORD(result_word),
		.FLAGS_NZCV(flags_nzcv));
	decoder_model bus (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// Free running 100 MHz clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (failures == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Control word from opcode, immediate and {higher, from register, set flags}.
	function automatic logic [31:0] c(input logic [4:0] o, input logic [5:0] i,
		input logic [2:0] m);
		return {18'h0, m[2], i, m[1:0], o};
	endfunction

	// Presets flags unless f[4], loads operands, executes, checks result and flags.
	// operands only ever come from the two data registers.
	task automatic t(input logic [4:0] f, input logic [31:0] a, b, w, er, input logic [3:0] ef);
		if (!f[4])
			bus.xfer(1'b1, 32'h10, {28'h0, f[3:0]}, r);
		bus.xfer(1'b1, 32'h0, a, r);
		bus.xfer(1'b1, 32'h4, b, r);
		bus.xfer(1'b1, 32'h8, w, r);
		bus.xfer(1'b0, 32'hc, 32'h0, r);
		chk(r, er);
		bus.xfer(1'b0, 32'h10, 32'h0, r);
		chk(r, {28'h0, ef});
		bus.xfer(1'b0, 32'h0, 32'h0, r);
		chk(r, a);
		chk(result_word, er);
		chk({28'h0, flags_nzcv}, {28'h0, ef});
	endtask

	// Main sequence after twelve cycles of reset.
	initial begin
		sys_rst = 1'b1;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		t(5'h05, va, vb, c(5'h00, 6'h0, 3'h0), va & vb, 4'h5);
		t(5'h03, va, vb, c(5'h01, 6'h0, 3'h1), va ^ vb, 4'hb);
		t(5'h00, va, vb, c(5'h02, 6'h0, 3'h1) | 32'hc000, va | vb, 4'ha);
		t(5'h00, va, vb, c(5'h03, 6'h0, 3'h0), va & ~vb, 4'h0);
		t(5'h02, va, vb, c(5'h04, 6'h0, 3'h1), va | ~vb, 4'ha);
		t(5'h09, va, ~va, c(5'h00, 6'h0, 3'h1), 32'h0, 4'h5);
		t(5'h01, va, vb, c(5'h05, 6'h04, 3'h1), 32'h0f01_2340, 4'h3);
		t(5'h02, va, 32'h108, c(5'h06, 6'h0, 3'h3), 32'h00f0_f012, 4'h0);
		t(5'h00, va, vb, c(5'h07, 6'h20, 3'h1), 32'hffff_ffff, 4'ha);
		t(5'h02, va, vb, c(5'h08, 6'h0c, 3'h1), 32'h234f_0f01, 4'h0);
		t(5'h02, va, vb, c(5'h09, 6'h05, 3'h1), 32'hf878_091a, 4'h8);
		t(5'h02, va, 32'h100, c(5'h05, 6'h0, 3'h3), va, 4'ha);
		t(5'h02, va, 32'hff, c(5'h05, 6'h0, 3'h3), 32'h0, 4'h4);
		t(5'h0f, 32'h0, vb, c(5'h0a, 6'h0, 3'h1), 32'h20, 4'hf);
		t(5'h06, 32'h1_0000, vb, c(5'h0a, 6'h0, 3'h0), 32'hf, 4'h6);
		t(5'h00, 32'hffff_ffff, 32'h1, c(5'h0b, 6'h0, 3'h1), 32'h0, 4'h6);
		t(5'h10, 32'h1, 32'h2, c(5'h0c, 6'h0, 3'h0), 32'h4, 4'h6);
		t(5'h00, 32'h0, 32'h1, c(5'h0d, 6'h0, 3'h1), 32'hffff_ffff, 4'h8);
		t(5'h10, 32'h5, 32'h2, c(5'h0e, 6'h0, 3'h1), 32'h2, 4'h2);
		t(5'h10, 32'h7, 32'h3, c(5'h0e, 6'h0, 3'h0), 32'h4, 4'h2);
		t(5'h06, 32'ha, 32'ha, c(5'h0c, 6'h0, 3'h4), 32'h4, 4'h6);
		t(5'h02, 32'ha, 32'ha, c(5'h0c, 6'h0, 3'h4), 32'h15, 4'h2);
		t(5'h09, 32'h3, 32'h3, c(5'h0f, 6'h0, 3'h0), 32'h15, 4'h6);
		t(5'h10, va, vb, c(5'h11, 6'h0, 3'h1), 32'h15, 4'h6);
		t(5'h00, 32'hffff_ffff, 32'h1, c(5'h10, 6'h0, 3'h0), 32'h15, 4'h6);
		bus.xfer(1'b0, 32'h8, 32'h0, r);
		chk(r, c(5'h10, 6'h0, 3'h0));
		bus.xfer(1'b0, 32'h20, 32'h0, r);
		chk(r, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		test_done();
	end

	// Cuts a hang short well after the sequence should have ended.
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		test_done();
	end
endmodule

`default_nettype wire
